// ===== verilog/priority_interrupt_request_unit.sv
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_request_unit
  import irq_prio_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  // Ordinary source pulses
  input  wire logic                timer_one_request,
  input  wire logic                timer_zero_request,
  input  wire logic                serial_rx_request,
  input  wire logic                serial_tx_request,
  input  wire logic                converter_request,
  input  wire logic                pin7_or_lowvolt_request,
  input  wire logic                pin6_or_comparator_request,
  input  wire logic [5:0]          port_a_pin_request,
  // Top rank sources
  input  wire logic                watchdog_level,
  input  wire logic                primary_osc_fail,
  input  wire logic                watchdog_osc_fail,
  input  wire logic                illegal_instruction,
  // Processor core
  output logic                     irq_req,
  output logic [4:0]               irq_vector,
  input  wire logic                irq_ack
);

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [7:0]     req_a_reg, req_a_next;
  logic [7:0]     req_b_reg, req_b_next;
  logic [7:0]     en_hi_a_reg, en_lo_a_reg, en_hi_b_reg, en_lo_b_reg;
  logic [1:0]     ctrl_reg, ctrl_next;
  logic [2:0]     trap_reg, trap_next;
  logic [4:0]     vec_reg;
  logic [31:0]    prdata_reg, rd_next;
  present_state_t state_reg, state_next;

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  logic [11:0] idx;
  logic        setup_rd, acc_wr, mapped;
  logic        wr_req_a, wr_req_b, wr_ctrl;
  logic [7:0]  wbyte;

  assign idx      = paddr[ADDR_W-1:2];
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr   = psel && penable && pwrite && pready && mapped;
  assign wbyte    = pwdata[7:0];
  assign mapped   = (idx == IDX_REQ_A) || (idx == IDX_REQ_B) || (idx == IDX_EN_HI_A)
                 || (idx == IDX_EN_LO_A) || (idx == IDX_EN_HI_B) || (idx == IDX_EN_LO_B)
                 || (idx == IDX_CTRL) || (idx == IDX_STATUS);
  assign wr_req_a = acc_wr && idx == IDX_REQ_A;
  assign wr_req_b = acc_wr && idx == IDX_REQ_B;
  assign wr_ctrl  = acc_wr && idx == IDX_CTRL;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (idx)
      IDX_REQ_A:   rd_next[7:0] = req_a_reg;
      IDX_REQ_B:   rd_next[7:0] = req_b_reg;
      IDX_EN_HI_A: rd_next[7:0] = en_hi_a_reg;
      IDX_EN_LO_A: rd_next[7:0] = en_lo_a_reg;
      IDX_EN_HI_B: rd_next[7:0] = en_hi_b_reg;
      IDX_EN_LO_B: rd_next[7:0] = en_lo_b_reg;
      IDX_CTRL:    rd_next[1:0] = ctrl_reg;
      IDX_STATUS:  rd_next[7:0] = {irq_req, 2'b00, vec_reg};
      default:     rd_next = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------
  // Enable registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_hi_a_reg <= REG_RESET;
      en_lo_a_reg <= REG_RESET;
      en_hi_b_reg <= REG_RESET;
      en_lo_b_reg <= REG_RESET;
    end else begin
      if (acc_wr && idx == IDX_EN_HI_A) en_hi_a_reg <= wbyte & BANK_A_MASK;
      if (acc_wr && idx == IDX_EN_LO_A) en_lo_a_reg <= wbyte & BANK_A_MASK;
      if (acc_wr && idx == IDX_EN_HI_B) en_hi_b_reg <= wbyte;
      if (acc_wr && idx == IDX_EN_LO_B) en_lo_b_reg <= wbyte;
    end
  end

  // --------------------------------------------------------------
  // Source ranking
  // --------------------------------------------------------------
  logic [15:0]          req_all, en_hi_all, en_lo_all;
  logic [NUM_SRC-1:0]   pend;
  logic [2*NUM_SRC-1:0] lvl;
  logic                 found;
  logic [3:0]           slot;

  assign req_all   = {req_b_reg, req_a_reg};
  assign en_hi_all = {en_hi_b_reg, en_hi_a_reg};
  assign en_lo_all = {en_lo_b_reg, en_lo_a_reg};

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      pend[i]        = req_all[src_pos(4'(i))];
      lvl[2*i +: 2]  = {en_hi_all[src_pos(4'(i))], en_lo_all[src_pos(4'(i))]};
    end
  end

  irq_prio_pick u_pick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pend    (pend),
    .lvl     (lvl),
    .found   (found),
    .slot    (slot)
  );

  // Top rank sources ahead of any configurable one
  logic       wdt_hit, any_win;
  logic [4:0] win_vec;

  assign wdt_hit = watchdog_level && ctrl_reg[CTRL_WDT_EN];
  assign any_win = wdt_hit || (|trap_reg) || found;
  assign win_vec = wdt_hit     ? VEC_WDT  :
                   trap_reg[0] ? VEC_POSC :
                   trap_reg[1] ? VEC_WOSC :
                   trap_reg[2] ? VEC_ILL  :
                   VEC_BASE + {1'b0, slot};

  // --------------------------------------------------------------
  // Presentation to the core
  // --------------------------------------------------------------
  logic        take_ack, ack_ord;
  logic [3:0]  ack_slot;
  logic [15:0] ack_clr;

  assign take_ack = state_reg == ST_PRESENT && irq_ack;
  assign ack_ord  = take_ack && vec_reg >= VEC_BASE;
  assign ack_slot = 4'(vec_reg - VEC_BASE);
  assign ack_clr  = ack_ord ? (16'h0001 << src_pos(ack_slot)) : 16'h0000;
  assign irq_req  = state_reg == ST_PRESENT;
  assign irq_vector = vec_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:    if (ctrl_reg[CTRL_GIE] && any_win) state_next = ST_PRESENT;
      ST_PRESENT: if (take_ack || !ctrl_reg[CTRL_GIE]) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      vec_reg   <= VEC_WDT;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE) vec_reg <= win_vec;
    end
  end

  // --------------------------------------------------------------
  // Request registers, traps and control
  // --------------------------------------------------------------
  logic [7:0] pulse_a, pulse_b;

  assign pulse_a = {1'b0, timer_one_request, timer_zero_request, serial_rx_request,
                    serial_tx_request, 2'b00, converter_request};
  assign pulse_b = {pin7_or_lowvolt_request, pin6_or_comparator_request,
                    port_a_pin_request};

  // Pulse wins over an acknowledge or a write in the same cycle
  assign req_a_next = (wr_req_a ? (wbyte & BANK_A_MASK)
                                : (req_a_reg & ~ack_clr[7:0])) | pulse_a;
  assign req_b_next = (wr_req_b ? wbyte : (req_b_reg & ~ack_clr[15:8])) | pulse_b;

  assign trap_next = (trap_reg & ~({3{take_ack}} & {vec_reg == VEC_ILL,
                                                    vec_reg == VEC_WOSC,
                                                    vec_reg == VEC_POSC}))
                   | {illegal_instruction, watchdog_osc_fail, primary_osc_fail};

  assign ctrl_next = {wr_ctrl ? wbyte[CTRL_WDT_EN] : ctrl_reg[CTRL_WDT_EN],
                      (wr_ctrl ? wbyte[CTRL_GIE] : ctrl_reg[CTRL_GIE]) && !take_ack};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_a_reg  <= REG_RESET;
      req_b_reg  <= REG_RESET;
      trap_reg   <= 3'b000;
      ctrl_reg   <= 2'b00;
      prdata_reg <= 32'h0000_0000;
    end else begin
      req_a_reg  <= req_a_next;
      req_b_reg  <= req_b_next;
      trap_reg   <= trap_next;
      ctrl_reg   <= ctrl_next;
      if (setup_rd) prdata_reg <= rd_next;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_pulse_sets;
    timer_one_request |=> req_a_reg[BIT_T1];
  endproperty
  a_pulse_sets: assert property (p_pulse_sets)
    else $error("timer 1 pulse not latched");

  property p_ack_clears;
    take_ack && vec_reg == VEC_BASE && !timer_one_request && !wr_req_a |=> !req_a_reg[BIT_T1];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge left timer 1 pending");

  property p_write_zero_clears;
    wr_req_a && !wbyte[BIT_T0] && !timer_zero_request |=> !req_a_reg[BIT_T0];
  endproperty
  a_write_zero_clears: assert property (p_write_zero_clears)
    else $error("write of 0 did not clear");

  property p_write_one_sets;
    wr_req_b && wbyte[2] |=> req_b_reg[2];
  endproperty
  a_write_one_sets: assert property (p_write_one_sets)
    else $error("write of 1 did not set");

  property p_forward;
    state_reg == ST_IDLE && ctrl_reg[CTRL_GIE] && found |=> irq_req;
  endproperty
  a_forward: assert property (p_forward)
    else $error("enabled request not presented");

  property p_disabled_quiet;
    !ctrl_reg[CTRL_GIE] |=> !irq_req;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("request presented while globally disabled");

  property p_ack_disables;
    irq_req && irq_ack |=> !ctrl_reg[CTRL_GIE] && !irq_req;
  endproperty
  a_ack_disables: assert property (p_ack_disables)
    else $error("global enable survived acknowledge");

  property p_watchdog_first;
    state_reg == ST_IDLE && ctrl_reg == 2'b11 && watchdog_level |=> irq_req && irq_vector == VEC_WDT;
  endproperty
  a_watchdog_first: assert property (p_watchdog_first)
    else $error("watchdog not presented first");

  property p_vector_stable;
    irq_req && !irq_ack ##1 irq_req |-> $stable(irq_vector);
  endproperty
  a_vector_stable: assert property (p_vector_stable)
    else $error("vector changed before acknowledge");

  property p_sw_request_clears;
    take_ack && vec_reg == VEC_BASE + 5'h04 && !converter_request && !wr_req_a
      |=> !req_a_reg[BIT_ADC];
  endproperty
  a_sw_request_clears: assert property (p_sw_request_clears)
    else $error("acknowledge left converter request pending");

  property p_polled_latch;
    !ctrl_reg[CTRL_GIE] && serial_rx_request |=> req_a_reg[BIT_RX] && !irq_req;
  endproperty
  a_polled_latch: assert property (p_polled_latch)
    else $error("request not latched while globally disabled");

  property p_pin_latch;
    port_a_pin_request[0] |=> req_b_reg[0];
  endproperty
  a_pin_latch: assert property (p_pin_latch)
    else $error("pin 0 pulse not latched");

  property p_lowvolt_latch;
    pin7_or_lowvolt_request |=> req_b_reg[7];
  endproperty
  a_lowvolt_latch: assert property (p_lowvolt_latch)
    else $error("pin 7 pulse not latched");

  property p_trap_bypass;
    state_reg == ST_IDLE && ctrl_reg[CTRL_GIE] && trap_reg[0] && !wdt_hit
      |=> irq_req && irq_vector == VEC_POSC;
  endproperty
  a_trap_bypass: assert property (p_trap_bypass)
    else $error("oscillator trap not presented ahead of sources");

  property p_trap_ack_clears;
    take_ack && vec_reg == VEC_ILL && !illegal_instruction |=> !trap_reg[2];
  endproperty
  a_trap_ack_clears: assert property (p_trap_ack_clears)
    else $error("acknowledge left illegal trap pending");

  c_ack: cover property (irq_req ##1 irq_req && irq_ack);
  c_sw_request: cover property (wr_req_a && wbyte[BIT_ADC] ##[1:4] irq_req);
  c_watchdog: cover property (wdt_hit && irq_req && irq_vector == VEC_WDT);
  c_trap: cover property (irq_req && irq_vector == VEC_ILL);
  c_polled: cover property (!ctrl_reg[CTRL_GIE] && req_b_reg == 8'hFF);

endmodule : priority_interrupt_request_unit
`default_nettype wire

// ===== verilog/irq_prio_pkg.sv
package irq_prio_pkg;

  // --------------------------------------------------------------
  // Bus and register map (word index; byte address is index * 4)
  // --------------------------------------------------------------
  localparam int          ADDR_W      = 14;
  localparam logic [11:0] IDX_REQ_A   = 12'hFC0;
  localparam logic [11:0] IDX_EN_HI_A = 12'hFC1;
  localparam logic [11:0] IDX_EN_LO_A = 12'hFC2;
  localparam logic [11:0] IDX_REQ_B   = 12'hFC3;
  localparam logic [11:0] IDX_EN_HI_B = 12'hFC4;
  localparam logic [11:0] IDX_EN_LO_B = 12'hFC5;
  localparam logic [11:0] IDX_CTRL    = 12'hFC8;
  localparam logic [11:0] IDX_STATUS  = 12'hFC9;

  // --------------------------------------------------------------
  // Field layout and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] BANK_A_MASK = 8'h79;
  localparam int         BIT_T1      = 6;
  localparam int         BIT_T0      = 5;
  localparam int         BIT_RX      = 4;
  localparam int         BIT_TX      = 3;
  localparam int         BIT_ADC     = 0;
  localparam int         CTRL_GIE    = 0;
  localparam int         CTRL_WDT_EN = 1;
  localparam int         STAT_REQ    = 7;

  // --------------------------------------------------------------
  // Sources and vector identities
  // --------------------------------------------------------------
  localparam int         NUM_SRC  = 13;
  localparam logic [4:0] VEC_WDT  = 5'h00;
  localparam logic [4:0] VEC_POSC = 5'h01;
  localparam logic [4:0] VEC_WOSC = 5'h02;
  localparam logic [4:0] VEC_ILL  = 5'h03;
  localparam logic [4:0] VEC_BASE = 5'h04;
  localparam logic [1:0] LVL_OFF  = 2'h0;
  localparam logic [1:0] LVL_TOP  = 2'h3;

  typedef enum logic {ST_IDLE, ST_PRESENT} present_state_t;

  // Bit position in {bank_b, bank_a} of source slot 0..12 (slot 0 ranks first)
  function automatic logic [3:0] src_pos(input logic [3:0] slot);
    unique case (slot)
      4'h0:    src_pos = 4'h6;
      4'h1:    src_pos = 4'h5;
      4'h2:    src_pos = 4'h4;
      4'h3:    src_pos = 4'h3;
      4'h4:    src_pos = 4'h0;
      default: src_pos = 4'(5'd20 - {1'b0, slot});
    endcase
  endfunction : src_pos

endpackage : irq_prio_pkg

// ===== verilog/irq_prio_pick.sv
`timescale 1ns/1ps
`default_nettype none
module irq_prio_pick
  import irq_prio_pkg::*;
(
  // Clock for checks
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Pending sources in fixed rank order and their two-bit levels
  input  wire logic [NUM_SRC-1:0]     pend,
  input  wire logic [2*NUM_SRC-1:0]   lvl,
  // Winner
  output logic                        found,
  output logic [3:0]                  slot
);

  logic [1:0] best_lvl;

  // Scan from last to first so an earlier slot wins a tie
  always_comb begin
    found    = 1'b0;
    slot     = 4'h0;
    best_lvl = LVL_OFF;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && lvl[2*i +: 2] != LVL_OFF && lvl[2*i +: 2] >= best_lvl) begin
        found    = 1'b1;
        slot     = 4'(i);
        best_lvl = lvl[2*i +: 2];
      end
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  logic any_top;
  assign any_top = |(pend & {lvl[24], lvl[22], lvl[20], lvl[18], lvl[16], lvl[14], lvl[12],
                             lvl[10], lvl[8], lvl[6], lvl[4], lvl[2], lvl[0]}
                          & {lvl[25], lvl[23], lvl[21], lvl[19], lvl[17], lvl[15], lvl[13],
                             lvl[11], lvl[9], lvl[7], lvl[5], lvl[3], lvl[1]});

  property p_top_level_wins;
    @(posedge clk_sys) disable iff (!reset_n)
    any_top |-> found && lvl[2*slot +: 2] == LVL_TOP;
  endproperty
  a_top_level_wins: assert property (p_top_level_wins)
    else $error("level 3 request did not win");

  property p_first_slot_rank;
    @(posedge clk_sys) disable iff (!reset_n)
    pend[0] && lvl[1:0] == LVL_TOP |-> slot == 4'h0;
  endproperty
  a_first_slot_rank: assert property (p_first_slot_rank)
    else $error("first ranked source lost at equal level");

  property p_disabled_ignored;
    @(posedge clk_sys) disable iff (!reset_n)
    found |-> lvl[2*slot +: 2] != LVL_OFF && pend[slot];
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored)
    else $error("disabled or idle source chosen");

endmodule : irq_prio_pick
`default_nettype wire

// ===== bench/core_ack_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_ack_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Controller side
  input  wire logic       irq_req,
  input  wire logic [4:0] irq_vector,
  output logic            irq_ack,
  // Bench side
  input  wire logic [3:0] ack_delay,
  output logic [7:0]      ack_count,
  output logic [4:0]      seen_vector
);
  logic [3:0] wait_reg;

  // ----------------------------------------------------------
  // Acknowledge once a request has stood for ack_delay cycles
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack     <= 1'b0;
      wait_reg    <= 4'h0;
      ack_count   <= 8'h00;
      seen_vector <= 5'h00;
    end else if (irq_ack) begin
      irq_ack     <= 1'b0;
      wait_reg    <= 4'h0;
      ack_count   <= ack_count + 8'h01;
      seen_vector <= irq_vector;
    end else if (irq_req && wait_reg == ack_delay) begin
      irq_ack <= 1'b1;
    end else if (irq_req) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      wait_reg <= 4'h0;
    end
  end
endmodule : core_ack_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irq_prio_pkg::*;
  logic              clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [15:0]       src_pulse;
  logic              watchdog_level, irq_req, irq_ack;
  logic [4:0]        irq_vector, seen_vector;
  logic [3:0]        ack_delay;
  logic [7:0]        ack_count, rdv, pend_a, pend_b, hi_a, lo_a, hi_b, lo_b;
  logic              errv, wdt_en, posc_flag, wosc_flag, ill_flag;
  int                err_count, check_count, cycles, rnd;

  always #25 clk_sys = ~clk_sys;

  priority_interrupt_request_unit priority_interrupt_request_unit_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata),
    .timer_one_request(src_pulse[0]), .timer_zero_request(src_pulse[1]),
    .serial_rx_request(src_pulse[2]), .serial_tx_request(src_pulse[3]),
    .converter_request(src_pulse[4]), .pin7_or_lowvolt_request(src_pulse[5]),
    .pin6_or_comparator_request(src_pulse[6]),
    .port_a_pin_request({src_pulse[7], src_pulse[8], src_pulse[9],
                         src_pulse[10], src_pulse[11], src_pulse[12]}),
    .watchdog_level(watchdog_level), .primary_osc_fail(src_pulse[13]),
    .watchdog_osc_fail(src_pulse[14]), .illegal_instruction(src_pulse[15]),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack));

  core_ack_model core_ack_model_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .ack_delay(ack_delay),
    .ack_count(ack_count), .seen_vector(seen_vector));

  // ----------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------
  function automatic int pos(input int s);
    case (s)
      0: return 6;
      1: return 5;
      2: return 4;
      3: return 3;
      4: return 0;
      default: return 20 - s;
    endcase
  endfunction : pos

  function automatic int exp_vec();
    int best, bl, l, p;
    logic [15:0] pd, h, lw;
    pd = {pend_b, pend_a};
    h = {hi_b, hi_a};
    lw = {lo_b, lo_a};
    if (watchdog_level && wdt_en) return 0;
    if (posc_flag) return 1;
    if (wosc_flag) return 2;
    if (ill_flag) return 3;
    best = -1;
    bl = 0;
    for (int s = 0; s < 13; s++) begin
      p = pos(s);
      l = 2 * h[p] + lw[p];
      if (pd[p] && l > bl) begin
        best = s + 4;
        bl = l;
      end
    end
    return best;
  endfunction : exp_vec

  // ----------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------
  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata[7:0];
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready", 8'(n < 50), 8'h01);
  endtask : apb

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp, input string name);
    apb(1'b0, idx, 8'h00);
    check(name, rdv, exp);
  endtask : rd_chk

  task automatic pulse(input logic [15:0] m);
    @(posedge clk_sys);
    src_pulse <= m;
    @(posedge clk_sys);
    src_pulse <= 16'h0000;
  endtask : pulse

  task automatic present_one();
    int e;
    int n;
    logic [7:0] prev;
    e = exp_vec();
    prev = ack_count;
    n = 0;
    apb(1'b1, IDX_CTRL, {6'h00, wdt_en, 1'b1});
    while (ack_count === prev && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check("ack_wait", 8'(n < 100), 8'h01);
    check("irq_vector", 8'(seen_vector), 8'(e));
    if (e >= 4) {pend_b, pend_a} = {pend_b, pend_a} & ~(16'h0001 << pos(e - 4));
    if (e == 1) posc_flag = 1'b0;
    if (e == 2) wosc_flag = 1'b0;
    if (e == 3) ill_flag = 1'b0;
    rd_chk(IDX_CTRL, {6'h00, wdt_en, 1'b0}, "ctrl");
    rd_chk(IDX_REQ_A, pend_a, "req_a");
    rd_chk(IDX_REQ_B, pend_b, "req_b");
  endtask : present_one

  task automatic drain();
    int k;
    k = 0;
    while (exp_vec() >= 0 && k < 20) begin
      present_one();
      k++;
    end
    apb(1'b1, IDX_CTRL, {6'h00, wdt_en, 1'b1});
    repeat (4) @(posedge clk_sys);
    check("irq_req idle", 8'(irq_req), 8'h00);
    apb(1'b1, IDX_CTRL, {6'h00, wdt_en, 1'b0});
  endtask : drain

  task automatic load_regs();
    apb(1'b1, IDX_EN_HI_A, hi_a);
    apb(1'b1, IDX_EN_LO_A, lo_a);
    apb(1'b1, IDX_EN_HI_B, hi_b);
    apb(1'b1, IDX_EN_LO_B, lo_b);
    apb(1'b1, IDX_REQ_A, pend_a);
    apb(1'b1, IDX_REQ_B, pend_b);
    rd_chk(IDX_EN_HI_A, hi_a, "en_hi_a");
    rd_chk(IDX_EN_LO_B, lo_b, "en_lo_b");
  endtask : load_regs

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    rnd = $urandom(7912);
    {clk_sys, reset_n, psel, penable, pwrite, watchdog_level} = 6'h00;
    {wdt_en, posc_flag, wosc_flag, ill_flag} = 4'h0;
    {paddr, pwdata, src_pulse, ack_delay} = '0;
    {pend_a, pend_b, hi_a, lo_a, hi_b, lo_b} = '0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(IDX_REQ_A, 8'h00, "req_a");
    rd_chk(IDX_REQ_B, 8'h00, "req_b");
    rd_chk(IDX_CTRL, 8'h00, "ctrl");
    apb(1'b0, 12'h010, 8'h00);
    check("pslverr", 8'(errv), 8'h01);
    check("prdata", rdv, 8'h00);
    for (int s = 0; s < 13; s++) begin
      pulse(16'h0001 << s);
      {pend_b, pend_a} = {pend_b, pend_a} | (16'h0001 << pos(s));
      rd_chk(IDX_REQ_A, pend_a, "req_a");
      rd_chk(IDX_REQ_B, pend_b, "req_b");
    end
    check("irq_req polled", 8'(irq_req), 8'h00);
    apb(1'b1, IDX_REQ_A, 8'h00);
    apb(1'b1, IDX_REQ_B, 8'h00);
    {pend_a, pend_b} = '0;
    rd_chk(IDX_REQ_A, 8'h00, "req_a");
    rd_chk(IDX_REQ_B, 8'h00, "req_b");
    for (int r = 0; r < 8; r++) begin
      hi_a = 8'($urandom) & 8'h79;
      lo_a = 8'($urandom) & 8'h79;
      hi_b = 8'($urandom);
      lo_b = 8'($urandom);
      pend_a = 8'($urandom) & 8'h79;
      pend_b = 8'($urandom);
      ack_delay <= 4'($urandom_range(5, 0));
      load_regs();
      drain();
    end
    {hi_a, lo_a, hi_b, lo_b} = {8'h79, 8'h79, 8'hFF, 8'hFF};
    load_regs();
    pulse(16'h1FFF);
    {pend_a, pend_b} = {8'h79, 8'hFF};
    wdt_en = 1'b1;
    watchdog_level <= 1'b1;
    @(posedge clk_sys);
    present_one();
    present_one();
    wdt_en = 1'b0;
    present_one();
    watchdog_level <= 1'b0;
    pulse(16'hE000);
    {posc_flag, wosc_flag, ill_flag} = 3'h7;
    drain();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
